// *** tb_top.sv ***
/*
  Self-checking bench for the mode and command controller.
  Assumes the host model vdm_host and the package vdm_pkg are compiled first.
*/
`default_nettype none
`define CHK(nm, e, g) check(nm, 32'(e), 32'(g))
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                 clk          = 1'b0;
  logic                 reset_n      = 1'b0;
  logic [3:0]           din_pin      = 4'h0;
  logic                 err_ind      = 1'b0;
  logic                 local_enable = 1'b0;
  vdm_pkg::vdm_bus_type bus;
  logic [31:0]          rdata;
  logic [3:0]           din_eff;
  logic [1:0]           dout;
  vdm_pkg::vdm_sol_type sol_a;
  vdm_pkg::vdm_sol_type sol_b;
  logic                 nv_save;
  int                   n_mismatch = 0;
  int                   n_checks   = 0;
  logic [31:0]          d;

  always #50 clk = ~clk;

  vdm_ctrl i_dut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .din_pin(din_pin),
    .err_ind(err_ind), .local_enable(local_enable), .din_eff(din_eff), .dout(dout),
    .sol_a(sol_a), .sol_b(sol_b), .nv_save(nv_save));
  vdm_host i_host (.clk(clk), .bus(bus), .rdata(rdata));

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic cmd(input logic [7:0] c);
    i_host.wr(vdm_pkg::ADDR_CMD, {24'h0, c});
  endtask : cmd

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt

  // Pin inputs move only just after a rising edge, like the host's strobes.
  task automatic drv_in(input logic [3:0] dp, input logic ei, input logic le);
    @(posedge clk);
    din_pin      <= dp;
    err_ind      <= ei;
    local_enable <= le;
  endtask : drv_in

  task automatic t_mode;
    cmd(vdm_pkg::CMD_ENABLE);
    i_host.rd(vdm_pkg::ADDR_STATUS, d);
    `CHK("status enable in local", 5'h00, d[4:0]);
    cmd(vdm_pkg::CMD_TO_LOCAL);
    i_host.rd(vdm_pkg::ADDR_STATUS, d);
    `CHK("status to-local in local", 5'h00, d[4:0]);
    drv_in(din_pin, err_ind, 1'b1);
    wt(3);
    cmd(vdm_pkg::CMD_TO_HOST);
    i_host.rd(vdm_pkg::ADDR_STATUS, d);
    `CHK("status to-host while active", 5'h04, d[4:0]);
    drv_in(din_pin, err_ind, 1'b0);
    wt(3);
    cmd(vdm_pkg::CMD_TO_HOST);
    drv_in(din_pin, err_ind, 1'b1);
    wt(3);
    i_host.rd(vdm_pkg::ADDR_STATUS, d);
    `CHK("status host ignores input", 5'h02, d[4:0]);
    drv_in(din_pin, err_ind, 1'b0);
    $display("test mode done");
  endtask : t_mode

  task automatic t_din;
    i_host.wr(vdm_pkg::ADDR_DIN_OVR, 32'h09);
    drv_in(4'b0101, err_ind, local_enable);
    wt(3);
    `CHK("din_eff a", 4'b0110, din_eff);
    drv_in(4'b1010, err_ind, local_enable);
    wt(3);
    `CHK("din_eff b", 4'b1010, din_eff);
    $display("test din done");
  endtask : t_din

  task automatic t_dout;
    i_host.wr(vdm_pkg::ADDR_DOUT_SEL, 32'h1);
    wt(3);
    `CHK("dout forced", 2'b01, dout);
    i_host.wr(vdm_pkg::ADDR_DOUT_SEL, 32'he);
    drv_in(din_pin, 1'b1, local_enable);
    wt(3);
    `CHK("dout error set", 2'b01, dout);
    drv_in(din_pin, 1'b0, local_enable);
    wt(3);
    `CHK("dout ready set", 2'b10, dout);
    $display("test dout done");
  endtask : t_dout

  // Each entry changes the signal type, so every write reloads the gain.
  task automatic t_gain;
    logic [3:0]  cfg [7] = '{4'h9, 4'hd, 4'h1, 4'h8, 4'hc, 4'h6, 4'h3};
    logic [15:0] exp [7] = '{16'd1000, 16'd1250, 16'd2000, 16'd500, 16'd625, 16'd1000,
                             16'd1000};
    for (int i = 0; i < 7; i++) begin
      i_host.wr(vdm_pkg::ADDR_CFG, {28'h0, cfg[i]});
      i_host.rd(vdm_pkg::ADDR_GAIN, d);
      `CHK("gain", exp[i], d[15:0]);
    end
    $display("test gain done");
  endtask : t_gain

  task automatic t_drive;
    i_host.wr(vdm_pkg::ADDR_CFG, 32'h1);
    i_host.wr(vdm_pkg::ADDR_IRANGE, 32'h044c_0064);
    i_host.setpoint(7'd50);
    cmd(vdm_pkg::CMD_ENABLE);
    i_host.rd(vdm_pkg::ADDR_STATUS, d);
    `CHK("status enabled", 3'h6, d[2:0]);
    cmd(vdm_pkg::CMD_START);
    wt(3);
    `CHK("sol_a started", {16'd600, 1'b1}, sol_a);
    `CHK("sol_b idle", 1'b0, sol_b.on);
    cmd(vdm_pkg::CMD_SEL_B);
    wt(3);
    `CHK("sol_b selected", {16'd600, 1'b1}, sol_b);
    `CHK("sol_a released", 1'b0, sol_a.on);
    i_host.setpoint(7'd100);
    wt(3);
    `CHK("sol_b full", {16'd1100, 1'b1}, sol_b);
    cmd(vdm_pkg::CMD_STOP);
    wt(3);
    `CHK("sol_b stopped", 17'h0, sol_b);
    cmd(vdm_pkg::CMD_START);
    cmd(vdm_pkg::CMD_DISABLE);
    wt(3);
    `CHK("sol_b disabled", 1'b0, sol_b.on);
    i_host.rd(vdm_pkg::ADDR_STATUS, d);
    `CHK("status disabled", 3'h2, d[2:0]);
    $display("test drive done");
  endtask : t_drive

  task automatic t_defaults;
    logic [31:0] n;
    // A gain away from the factory value makes the restore visible.
    i_host.wr(vdm_pkg::ADDR_GAIN, 32'h0000_1234);
    cmd(vdm_pkg::CMD_ENABLE);
    cmd(vdm_pkg::CMD_DEFAULTS);
    n = '0;
    repeat (4) @(negedge clk) n += 32'(nv_save);
    `CHK("save while active", 0, n);
    cmd(vdm_pkg::CMD_DISABLE);
    cmd(vdm_pkg::CMD_DEFAULTS);
    n = '0;
    repeat (4) @(negedge clk) n += 32'(nv_save);
    `CHK("save pulses", 1, n);
    i_host.rd(vdm_pkg::ADDR_GAIN, d);
    `CHK("default gain", 16'd1000, d[15:0]);
    i_host.rd(vdm_pkg::ADDR_IRANGE, d);
    `CHK("default range", 32'h03e8_0000, d);
    i_host.rd(vdm_pkg::ADDR_CFG, d);
    `CHK("default cfg", 4'h0, d[3:0]);
    i_host.rd(vdm_pkg::ADDR_DIN_OVR, d);
    `CHK("default overrides", 8'h00, d[7:0]);
    cmd(vdm_pkg::CMD_SEL_A);
    cmd(vdm_pkg::CMD_SEL_B);
    i_host.rd(vdm_pkg::ADDR_STATUS, d);
    `CHK("select ignored single solenoid", 1'b0, d[4]);
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_local;
    cmd(vdm_pkg::CMD_TO_LOCAL);
    drv_in(din_pin, err_ind, 1'b1);
    cmd(vdm_pkg::CMD_START);
    wt(3);
    `CHK("no direct drive", 2'b00, {sol_a.on, sol_b.on});
    i_host.rd(vdm_pkg::ADDR_STATUS, d);
    `CHK("status local", 3'h0, {d[3], d[1:0]});
    i_host.rd(4'hf, d);
    `CHK("unmapped read", 32'h0, d);
    $display("test local done");
  endtask : t_local

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_gain();
    t_mode();
    t_din();
    t_dout();
    t_drive();
    t_defaults();
    t_local();
    end_sim();
  end

  // The whole run takes well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire

// *** vdm_ctrl.sv ***
/*
  Mode and command controller of a proportional valve driver.
  Assumes inputs synchronous to clk; the nonvolatile store acknowledges
  a save request on its own, outside this block.
*/
// The address-and-strobe port and the register addresses are this design's own decisions.
`default_nettype none
module vdm_ctrl (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // Register port
  input  wire vdm_pkg::vdm_bus_type     bus,
  output var  logic [31:0]              rdata,
  // Pins and internal indications
  input  wire logic [vdm_pkg::NUM_DIN-1:0]  din_pin,
  input  wire logic                     err_ind,
  input  wire logic                     local_enable,
  output var  logic [vdm_pkg::NUM_DIN-1:0]  din_eff,
  output var  logic [vdm_pkg::NUM_DOUT-1:0] dout,
  // Solenoid drive and nonvolatile store
  output var  vdm_pkg::vdm_sol_type     sol_a,
  output var  vdm_pkg::vdm_sol_type     sol_b,
  output var  logic                     nv_save
);
  vdm_pkg::vdm_mode_type  mode_r;
  vdm_pkg::vdm_state_type state_r;
  vdm_pkg::vdm_opmode_type opm_r;
  vdm_pkg::vdm_sig_type   sig_r;
  logic [6:0]  setpt_r;
  logic [15:0] imin_r, imax_r, gain_r;
  logic        run_r, sel_b_r;
  logic [2*vdm_pkg::NUM_DIN-1:0]  din_ovr_r;
  logic [2*vdm_pkg::NUM_DOUT-1:0] dout_sel_r;

  // Command decode.
  wire        cmd_wr   = bus.wr && bus.addr == vdm_pkg::ADDR_CMD;
  wire [7:0]  cmd      = bus.wdata[7:0];
  wire        is_host  = mode_r == vdm_pkg::MODE_HOST;
  wire        is_dis   = state_r == vdm_pkg::ST_DISABLED;
  // Direct actuation only in host-driven mode; otherwise ignored.
  wire        act_ok   = cmd_wr && is_host;
  wire        go_start = act_ok && cmd == vdm_pkg::CMD_START;
  wire        go_stop  = act_ok && cmd == vdm_pkg::CMD_STOP;
  wire        go_sel_a = act_ok && cmd == vdm_pkg::CMD_SEL_A;
  wire        go_sel_b = act_ok && cmd == vdm_pkg::CMD_SEL_B &&
                         opm_r != vdm_pkg::OPM_UNI1;
  wire        go_host  = cmd_wr && is_dis && !is_host &&
                         cmd == vdm_pkg::CMD_TO_HOST;
  wire        go_local = cmd_wr && is_dis && is_host &&
                         cmd == vdm_pkg::CMD_TO_LOCAL;
  wire        go_en    = act_ok && cmd == vdm_pkg::CMD_ENABLE;
  wire        go_dis   = act_ok && cmd == vdm_pkg::CMD_DISABLE;
  wire        go_def   = cmd_wr && is_dis && cmd == vdm_pkg::CMD_DEFAULTS;

  // Configuration writes; a change of signal type reloads the gain.
  wire        cfg_wr   = bus.wr && bus.addr == vdm_pkg::ADDR_CFG;
  wire vdm_pkg::vdm_opmode_type opm_new =
    vdm_pkg::vdm_opmode_type'(bus.wdata[vdm_pkg::CFG_OPMODE_LSB +: 2]);
  wire vdm_pkg::vdm_sig_type sig_new =
    vdm_pkg::vdm_sig_type'(bus.wdata[vdm_pkg::CFG_SIG_LSB +: 2]);
  wire        sig_chg  = cfg_wr && sig_new != sig_r;
  wire        gain_wr  = bus.wr && bus.addr == vdm_pkg::ADDR_GAIN;

  // Default gain table: two-solenoid unipolar (OPM_UNI2) doubles the base value except with SIG_PM10V.
  logic [15:0] gain_base, gain_def;
  always_comb begin
    case (sig_new)
      vdm_pkg::SIG_MA20:   gain_base = vdm_pkg::GAIN_5_PMA;
      vdm_pkg::SIG_MA4_20: gain_base = vdm_pkg::GAIN_625_PMA;
      default:             gain_base = vdm_pkg::GAIN_10_PV;
    endcase
    if (opm_new == vdm_pkg::OPM_UNI2 && sig_new != vdm_pkg::SIG_PM10V) begin
      gain_def = {gain_base[14:0], 1'b0};
    end else begin
      gain_def = gain_base;
    end
  end

  // Linear map of 0..100 percent onto imin..imax.
  wire [15:0] span    = imax_r - imin_r;
  wire [22:0] prod    = span * setpt_r;
  wire [15:0] scaled  = 16'(prod / 23'(vdm_pkg::SETPT_FULL));
  wire [15:0] i_cmd   = imin_r + scaled;
  // Outputs carry current only while active, host-driven and started.
  wire        drive   = is_host && state_r == vdm_pkg::ST_ACTIVE && run_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r  <= vdm_pkg::MODE_LOCAL;
      state_r <= vdm_pkg::ST_DISABLED;
    end else begin
      if (go_host) begin
        mode_r <= vdm_pkg::MODE_HOST;
      end else if (go_local) begin
        mode_r <= vdm_pkg::MODE_LOCAL;
      end
      if (go_en) begin
        state_r <= vdm_pkg::ST_ACTIVE;
      end else if (go_dis) begin
        state_r <= vdm_pkg::ST_DISABLED;
      end else if (!is_host) begin
        // Inputs steer the local state only outside host-driven mode.
        state_r <= local_enable ? vdm_pkg::ST_ACTIVE : vdm_pkg::ST_DISABLED;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_r   <= 1'b0;
      sel_b_r <= 1'b0;
      setpt_r <= 7'h00;
    end else begin
      if (go_start) begin
        run_r <= 1'b1;
      end else if (go_stop || go_local) begin
        run_r <= 1'b0;
      end
      if (go_sel_b) begin
        sel_b_r <= 1'b1;
      end else if (go_sel_a) begin
        sel_b_r <= 1'b0;
      end
      // Values above full scale are clipped; the host owns the range.
      if (bus.wr && bus.addr == vdm_pkg::ADDR_SETPT && is_host) begin
        setpt_r <= (bus.wdata[6:0] > vdm_pkg::SETPT_FULL) ?
                   vdm_pkg::SETPT_FULL : bus.wdata[6:0];
      end
    end
  end

  // Parameter set; factory defaults override writes in the same cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      opm_r      <= vdm_pkg::OPM_UNI1;
      sig_r      <= vdm_pkg::SIG_V10;
      gain_r     <= vdm_pkg::GAIN_10_PV;
      imin_r     <= vdm_pkg::DEF_IMIN;
      imax_r     <= vdm_pkg::DEF_IMAX;
      din_ovr_r  <= '0;
      dout_sel_r <= '0;
      nv_save    <= 1'b0;
    end else begin
      nv_save <= go_def;
      if (go_def) begin
        opm_r      <= vdm_pkg::OPM_UNI1;
        sig_r      <= vdm_pkg::SIG_V10;
        gain_r     <= vdm_pkg::GAIN_10_PV;
        imin_r     <= vdm_pkg::DEF_IMIN;
        imax_r     <= vdm_pkg::DEF_IMAX;
        din_ovr_r  <= '0;
        dout_sel_r <= '0;
      end else begin
        if (cfg_wr) begin
          opm_r <= opm_new;
          sig_r <= sig_new;
        end
        if (sig_chg) begin
          gain_r <= gain_def;
        end else if (gain_wr) begin
          gain_r <= bus.wdata[15:0];
        end
        if (bus.wr && bus.addr == vdm_pkg::ADDR_IRANGE) begin
          imin_r <= bus.wdata[15:0];
          imax_r <= bus.wdata[31:16];
        end
        if (bus.wr && bus.addr == vdm_pkg::ADDR_DIN_OVR) begin
          din_ovr_r <= bus.wdata[2*vdm_pkg::NUM_DIN-1:0];
        end
        if (bus.wr && bus.addr == vdm_pkg::ADDR_DOUT_SEL) begin
          dout_sel_r <= bus.wdata[2*vdm_pkg::NUM_DOUT-1:0];
        end
      end
    end
  end

  // Digital input overrides and output selection.
  logic [vdm_pkg::NUM_DIN-1:0]  din_nxt;
  logic [vdm_pkg::NUM_DOUT-1:0] dout_nxt;
  always_comb begin
    for (int i = 0; i < vdm_pkg::NUM_DIN; i++) begin
      case (din_ovr_r[2*i +: 2])
        vdm_pkg::DIN_ONE:  din_nxt[i] = 1'b1;
        vdm_pkg::DIN_ZERO: din_nxt[i] = 1'b0;
        default:           din_nxt[i] = din_pin[i];
      endcase
    end
    for (int j = 0; j < vdm_pkg::NUM_DOUT; j++) begin
      case (dout_sel_r[2*j +: 2])
        vdm_pkg::DOUT_ONE:   dout_nxt[j] = 1'b1;
        vdm_pkg::DOUT_ERROR: dout_nxt[j] = err_ind;
        vdm_pkg::DOUT_READY: dout_nxt[j] = !err_ind;
        default:             dout_nxt[j] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      din_eff <= '0;
      dout    <= '0;
      sol_a   <= '0;
      sol_b   <= '0;
    end else begin
      din_eff <= din_nxt;
      dout    <= dout_nxt;
      sol_a   <= '{current: (drive && !sel_b_r) ? i_cmd : 16'h0000,
                   on: drive && !sel_b_r};
      sol_b   <= '{current: (drive && sel_b_r) ? i_cmd : 16'h0000,
                   on: drive && sel_b_r};
    end
  end

  // Register read-back, one cycle after the read strobe; unmapped reads zero.
  logic [31:0] rd_nxt;
  always_comb begin
    if (bus.addr == vdm_pkg::ADDR_SETPT) begin
      rd_nxt = {25'h0000000, setpt_r};
    end else if (bus.addr == vdm_pkg::ADDR_CFG) begin
      rd_nxt = {28'h0000000, sig_r, opm_r};
    end else if (bus.addr == vdm_pkg::ADDR_DIN_OVR) begin
      rd_nxt = {24'h000000, din_ovr_r};
    end else if (bus.addr == vdm_pkg::ADDR_DOUT_SEL) begin
      rd_nxt = {28'h0000000, dout_sel_r};
    end else if (bus.addr == vdm_pkg::ADDR_IRANGE) begin
      rd_nxt = {imax_r, imin_r};
    end else if (bus.addr == vdm_pkg::ADDR_STATUS) begin
      rd_nxt = {27'h0000000, sel_b_r, run_r, state_r, mode_r};
    end else if (bus.addr == vdm_pkg::ADDR_GAIN) begin
      rd_nxt = {16'h0000, gain_r};
    end else if (bus.addr == vdm_pkg::ADDR_DIN) begin
      rd_nxt = {28'h0000000, din_eff};
    end else begin
      rd_nxt = 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= bus.rd ? rd_nxt : 32'h00000000;
    end
  end

  property p_mode_only_disabled;
    @(posedge clk) disable iff (!reset_n)
    (mode_r != $past(mode_r)) |-> $past(state_r) == vdm_pkg::ST_DISABLED;
  endproperty
  a_mode_only_disabled: assert property (p_mode_only_disabled)
    else $error("mode changed while not disabled");

  property p_to_host;
    @(posedge clk) disable iff (!reset_n)
    go_host |=> mode_r == vdm_pkg::MODE_HOST;
  endproperty
  a_to_host: assert property (p_to_host)
    else $error("switch to host mode lost");

  property p_to_local;
    @(posedge clk) disable iff (!reset_n)
    go_local |=> mode_r == vdm_pkg::MODE_LOCAL ##1 !sol_a.on && !sol_b.on;
  endproperty
  a_to_local: assert property (p_to_local)
    else $error("switch to local mode lost or drive kept");

  property p_enable;
    @(posedge clk) disable iff (!reset_n)
    go_en |=> state_r == vdm_pkg::ST_ACTIVE;
  endproperty
  a_enable: assert property (p_enable)
    else $error("enable did not activate");

  property p_disable;
    @(posedge clk) disable iff (!reset_n)
    go_dis |=> state_r == vdm_pkg::ST_DISABLED ##1 !sol_a.on && !sol_b.on;
  endproperty
  a_disable: assert property (p_disable)
    else $error("disable did not stop outputs");

  property p_stop_zero;
    @(posedge clk) disable iff (!reset_n)
    go_stop |=> ##1 sol_a.current == 16'h0000 && sol_b.current == 16'h0000;
  endproperty
  a_stop_zero: assert property (p_stop_zero)
    else $error("stop left current on solenoid");

  property p_defaults;
    @(posedge clk) disable iff (!reset_n)
    go_def |=> nv_save && gain_r == vdm_pkg::GAIN_10_PV && imax_r == vdm_pkg::DEF_IMAX;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("factory defaults not restored");

  property p_gain_load;
    @(posedge clk) disable iff (!reset_n)
    sig_chg && !go_def |=> gain_r == $past(gain_def);
  endproperty
  a_gain_load: assert property (p_gain_load)
    else $error("default gain not loaded on signal type change");

  property p_local_ignore;
    @(posedge clk) disable iff (!reset_n)
    cmd_wr && !is_host && cmd == vdm_pkg::CMD_START |=> run_r == $past(run_r);
  endproperty
  a_local_ignore: assert property (p_local_ignore)
    else $error("actuation accepted outside host mode");
endmodule : vdm_ctrl
`default_nettype wire

// *** vdm_host.sv ***
/*
  Host model for the mode and command controller: issues register writes
  and reads on the plain strobe port the way the configuration host does.
  Assumes a free-running clk and a slave that never makes it wait.
*/
`default_nettype none
module vdm_host (
  // Clock
  input  wire logic                 clk,
  // Register port toward the device
  output var  vdm_pkg::vdm_bus_type bus,
  input  wire logic [31:0]          rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial bus = '0;

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd

  // A host never asks for more than full scale.
  task automatic setpoint(input logic [6:0] pct);
    wr(vdm_pkg::ADDR_SETPT, {25'h0, (pct > 7'h64) ? 7'h64 : pct});
  endtask : setpoint
endmodule : vdm_host
`default_nettype wire

// *** vdm_pkg.sv ***
/*
  Package for the valve driver mode and command controller: register map,
  field codes, gain table values and state enumerations.
  Assumes a single 10 MHz clock domain and a plain strobe register port.
*/
`default_nettype none
package vdm_pkg;
  // Register offsets (word addresses on the plain port).
  localparam logic [3:0] ADDR_CMD     = 4'h0;
  localparam logic [3:0] ADDR_SETPT   = 4'h1;
  localparam logic [3:0] ADDR_CFG     = 4'h2;
  localparam logic [3:0] ADDR_DIN_OVR = 4'h3;
  localparam logic [3:0] ADDR_DOUT_SEL = 4'h4;
  localparam logic [3:0] ADDR_IRANGE  = 4'h5;
  localparam logic [3:0] ADDR_STATUS  = 4'h6;
  localparam logic [3:0] ADDR_GAIN    = 4'h7;
  localparam logic [3:0] ADDR_DIN     = 4'h8;

  // Command codes written to the command register.
  localparam logic [7:0] CMD_START   = 8'h01;
  localparam logic [7:0] CMD_STOP    = 8'h02;
  localparam logic [7:0] CMD_SEL_A   = 8'h03;
  localparam logic [7:0] CMD_SEL_B   = 8'h04;
  localparam logic [7:0] CMD_TO_HOST = 8'h05;
  localparam logic [7:0] CMD_TO_LOCAL = 8'h06;
  localparam logic [7:0] CMD_ENABLE  = 8'h07;
  localparam logic [7:0] CMD_DISABLE = 8'h08;
  localparam logic [7:0] CMD_DEFAULTS = 8'h09;

  // Input override codes (two bits per input).
  localparam logic [1:0] DIN_PIN  = 2'h0;
  localparam logic [1:0] DIN_ZERO = 2'h1;
  localparam logic [1:0] DIN_ONE  = 2'h2;
  // Output select codes (two bits per output).
  localparam logic [1:0] DOUT_ZERO  = 2'h0;
  localparam logic [1:0] DOUT_ONE   = 2'h1;
  localparam logic [1:0] DOUT_ERROR = 2'h2;
  localparam logic [1:0] DOUT_READY = 2'h3;

  localparam int NUM_DIN  = 4;
  localparam int NUM_DOUT = 2;

  // Gains in units of 0.01 %/V or 0.01 %/mA.
  localparam logic [15:0] GAIN_10_PV   = 16'h03e8;
  localparam logic [15:0] GAIN_5_PMA   = 16'h01f4;
  localparam logic [15:0] GAIN_625_PMA = 16'h0271;

  // Field positions in the configuration register.
  localparam int CFG_OPMODE_LSB = 0;
  localparam int CFG_SIG_LSB    = 2;

  // Factory defaults and setpoint full scale.
  localparam logic [15:0] DEF_IMIN = 16'h0000;
  localparam logic [15:0] DEF_IMAX = 16'h03e8;
  localparam logic [6:0]  SETPT_FULL = 7'h64;

  typedef enum logic [1:0] {OPM_UNI1, OPM_UNI2, OPM_BIPOLAR, OPM_UNI2_SINGLE} vdm_opmode_type;
  typedef enum logic [1:0] {SIG_V10, SIG_PM10V, SIG_MA20, SIG_MA4_20} vdm_sig_type;
  typedef enum logic [1:0] {MODE_LOCAL, MODE_REMOTE, MODE_HOST} vdm_mode_type;
  typedef enum logic {ST_DISABLED, ST_ACTIVE} vdm_state_type;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } vdm_bus_type;

  typedef struct packed {
    logic [15:0] current;
    logic        on;
  } vdm_sol_type;
endpackage : vdm_pkg
`default_nettype wire
